// [emb_pkg.sv]
// Shared constants and types for the external memory bus port
package emb_pkg;

	// ----------------------------------------------------------------
	// Address space and internal program store
	// ----------------------------------------------------------------
	localparam int EMB_ADDR_W = 16;
	localparam int EMB_INT_ROM_BYTES = 4096;
	localparam logic [7:0] EMB_AUX_CTRL_ADDR = 8'h8e;
	localparam int EMB_LATCH_OFF_BIT = 0;

	// ----------------------------------------------------------------
	// Timing in oscillator clocks; reset length in machine cycles
	// ----------------------------------------------------------------
	localparam int EMB_MACHINE_CLKS = 12;
	localparam int EMB_RESET_MCYCLES = 2;
	localparam int EMB_ALE_CLKS = 2;
	localparam int EMB_SETUP_CLKS = 1;
	localparam int EMB_CODE_STB_CLKS = 3;
	localparam int EMB_DATA_STB_CLKS = 6;
	localparam int EMB_ALE_PERIOD_CLKS = EMB_MACHINE_CLKS / 2;

	// ----------------------------------------------------------------
	// Request kinds, sequencer states and reset values
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		EMB_KIND_FETCH = 2'h0,
		EMB_KIND_CODE_READ = 2'h1,
		EMB_KIND_DATA_READ = 2'h2,
		EMB_KIND_DATA_WRITE = 2'h3
	} emb_kind_e;

	typedef enum logic [4:0] {
		EMB_ST_IDLE = 5'h01,
		EMB_ST_ADDR = 5'h02,
		EMB_ST_SETUP = 5'h04,
		EMB_ST_STROBE = 5'h08,
		EMB_ST_TAIL = 5'h10
	} emb_state_e;

	localparam logic [7:0] EMB_RST_BYTE = 8'h00;
	localparam logic [15:0] EMB_RST_ADDR = 16'h0000;

endpackage : emb_pkg

// [emb_bus_port.sv]
// External program/data memory bus port with multiplexed low address/data
// Contract
// - Select low: every fetch goes external
// - Internal fetch: no address or code on bus
// - Program strobe asserted for external code reads
// - Program strobe silent for internal code reads
// - Latch strobe lets latch capture low address
// - Reset pin high two machine cycles resets
// - Low port carries address, then data byte
// - High port carries upper address byte
// - Write strobe asserted for external data writes
// - Read strobe asserted for external data reads
// - Separate 64K code and data, 16-bit address
// - Suppress bit stops free latch strobe toggling
// - Suppressed strobe still pulses on external accesses
`timescale 1ns/1ps
`default_nettype none

module emb_bus_port #(
	parameter int INT_ROM_BYTES = emb_pkg::EMB_INT_ROM_BYTES,
	parameter int MACHINE_CLKS = emb_pkg::EMB_MACHINE_CLKS
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic resetPin,
	input wire logic externalAccessSelectPin,
	input wire logic latchStrobeOff,
	input wire logic reqValid,
	input wire emb_pkg::emb_kind_e reqKind,
	input wire logic [emb_pkg::EMB_ADDR_W-1:0] reqAddr,
	input wire logic [7:0] reqWrData,
	output logic reqReady,
	output logic reqDone,
	output logic reqInternal,
	output logic [7:0] reqRdData,
	output logic coreReset,
	input wire logic [7:0] lowAddrDataPortIn,
	output logic [7:0] lowAddrDataPortOut,
	output logic lowAddrDataPortOe,
	output logic [7:0] highAddrPortOut,
	output logic highAddrPortOe,
	output logic latchStrobe,
	output logic programStoreStrobe_n,
	output logic dataReadStrobe_n,
	output logic dataWriteStrobe_n
);
	import emb_pkg::*;

	localparam int RESET_CLKS = EMB_RESET_MCYCLES * MACHINE_CLKS;
	localparam logic [5:0] RESET_CNT_MAX = 6'(RESET_CLKS - 1);
	localparam logic [3:0] ALE_LAST = 4'(EMB_ALE_CLKS - 1);
	localparam logic [3:0] SETUP_LAST = 4'(EMB_SETUP_CLKS - 1);
	localparam logic [3:0] CODE_LAST = 4'(EMB_CODE_STB_CLKS - 1);
	localparam logic [3:0] DATA_LAST = 4'(EMB_DATA_STB_CLKS - 1);
	localparam logic [3:0] ALE_HIGH = 4'(EMB_ALE_CLKS);
	localparam logic [3:0] DIV_LAST = 4'(EMB_ALE_PERIOD_CLKS - 1);
	localparam logic [16:0] INT_LIMIT = 17'(INT_ROM_BYTES);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	if (INT_ROM_BYTES < 1 || INT_ROM_BYTES > 65536)
	begin : g_bad_rom
		$error("INT_ROM_BYTES must lie in 1..65536");
	end
	if (MACHINE_CLKS < 12 || RESET_CLKS > 64)
	begin : g_bad_mc
		$error("MACHINE_CLKS must lie in 12..32");
	end

	// ----------------------------------------------------------------
	// Pin synchronisers: three stages, change once stages 2 and 3 agree
	// ----------------------------------------------------------------
	logic [2:0] selSync_q;
	logic [2:0] rstSync_q;
	logic [7:0] busSync1_q, busSync2_q, busSync3_q;
	logic selLevel_q;
	logic rstLevel_q;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			selSync_q <= 3'h0;
			rstSync_q <= 3'h0;
			busSync1_q <= EMB_RST_BYTE;
			busSync2_q <= EMB_RST_BYTE;
			busSync3_q <= EMB_RST_BYTE;
		end
		else
		begin
			selSync_q <= {selSync_q[1:0], externalAccessSelectPin};
			rstSync_q <= {rstSync_q[1:0], resetPin};
			busSync1_q <= lowAddrDataPortIn;
			busSync2_q <= busSync1_q;
			busSync3_q <= busSync2_q;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			selLevel_q <= 1'b0;
			rstLevel_q <= 1'b0;
		end
		else
		begin
			if (selSync_q[1] == selSync_q[2])
				selLevel_q <= selSync_q[2];
			if (rstSync_q[1] == rstSync_q[2])
				rstLevel_q <= rstSync_q[2];
		end
	end

	// ----------------------------------------------------------------
	// Reset pin qualification
	// ----------------------------------------------------------------
	logic [5:0] rstCnt_q;
	logic coreReset_q;
	wire logic rstReached = (rstCnt_q == RESET_CNT_MAX);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstCnt_q <= 6'h00;
			coreReset_q <= 1'b1;
		end
		else if (!rstLevel_q)
		begin
			rstCnt_q <= 6'h00;
			coreReset_q <= 1'b0;
		end
		else if (rstReached)
			coreReset_q <= 1'b1;
		else
			rstCnt_q <= rstCnt_q + 6'h01;
	end

	// ----------------------------------------------------------------
	// Access sequencer
	// ----------------------------------------------------------------
	emb_state_e state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	emb_kind_e kind_q;
	logic [15:0] addr_q;
	logic [7:0] wrData_q;
	logic [3:0] aleDiv_q;
	logic started_q;
	logic reqReady_q;

	wire logic reqIsCode = (reqKind == EMB_KIND_FETCH) || (reqKind == EMB_KIND_CODE_READ);
	// Internal only with select high and address inside the on-chip store
	wire logic inInternal = ({1'b0, reqAddr} < INT_LIMIT);
	wire logic internalHit = reqIsCode && selLevel_q && inInternal;
	wire logic accept = reqValid && reqReady_q && !coreReset_q;
	wire logic goExternal = accept && !internalHit;
	wire logic goInternal = accept && internalHit;
	wire logic curCode = (kind_q == EMB_KIND_FETCH) || (kind_q == EMB_KIND_CODE_READ);
	wire logic curWrite = (kind_q == EMB_KIND_DATA_WRITE);
	// Extend strobe while the sampled bus is still settling
	wire logic busStable = (busSync2_q == busSync3_q);
	wire logic lastCnt = (cnt_q == 4'h0);

	always_comb
	begin
		state_d = state_q;
		cnt_d = (cnt_q == 4'h0) ? 4'h0 : cnt_q - 4'h1;
		case (state_q)
			EMB_ST_IDLE:
				if (goExternal)
				begin
					state_d = EMB_ST_ADDR;
					cnt_d = ALE_LAST;
				end
			EMB_ST_ADDR:
				if (lastCnt)
				begin
					state_d = EMB_ST_SETUP;
					cnt_d = SETUP_LAST;
				end
			EMB_ST_SETUP:
				if (lastCnt)
				begin
					state_d = EMB_ST_STROBE;
					cnt_d = curCode ? CODE_LAST : DATA_LAST;
				end
			EMB_ST_STROBE:
				if (lastCnt && (curWrite || busStable))
					state_d = EMB_ST_TAIL;
			EMB_ST_TAIL:
				state_d = EMB_ST_IDLE;
			default:
				state_d = EMB_ST_IDLE;
		endcase
		if (coreReset_q)
		begin
			state_d = EMB_ST_IDLE;
			cnt_d = 4'h0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= EMB_ST_IDLE;
			cnt_q <= 4'h0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			kind_q <= EMB_KIND_FETCH;
			addr_q <= EMB_RST_ADDR;
			wrData_q <= EMB_RST_BYTE;
		end
		else if (accept)
		begin
			kind_q <= reqKind;
			addr_q <= reqAddr;
			wrData_q <= reqWrData;
		end
	end

	// Free-running latch strobe divider, also marks the first fetch
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aleDiv_q <= 4'h0;
			started_q <= 1'b0;
		end
		else
		begin
			aleDiv_q <= (aleDiv_q == DIV_LAST) ? 4'h0 : aleDiv_q + 4'h1;
			if (coreReset_q)
				started_q <= 1'b0;
			else if (accept && reqKind == EMB_KIND_FETCH)
				started_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Next pin values; all outputs leave from flip-flops
	// ----------------------------------------------------------------
	wire emb_kind_e kindN = accept ? reqKind : kind_q;
	wire logic [15:0] addrN = accept ? reqAddr : addr_q;
	wire logic [7:0] wrDataN = accept ? reqWrData : wrData_q;
	wire logic codeN = (kindN == EMB_KIND_FETCH) || (kindN == EMB_KIND_CODE_READ);
	wire logic writeN = (kindN == EMB_KIND_DATA_WRITE);
	wire logic addrPhaseN = (state_d == EMB_ST_ADDR) || (state_d == EMB_ST_SETUP);
	wire logic dataPhaseN = (state_d == EMB_ST_STROBE) || (state_d == EMB_ST_TAIL);
	wire logic strobeN = (state_d == EMB_ST_STROBE);
	wire logic busyN = (state_d != EMB_ST_IDLE);
	// Idle toggling only when not suppressed and after the first fetch
	wire logic freeAle = !latchStrobeOff && started_q && !coreReset_q && (aleDiv_q < ALE_HIGH);
	wire logic aleN = (state_d == EMB_ST_ADDR) || ((state_d == EMB_ST_IDLE) && freeAle);
	wire logic lowOeN = addrPhaseN || (dataPhaseN && writeN);
	wire logic [7:0] lowOutN = addrPhaseN ? addrN[7:0] : wrDataN;
	wire logic capture = (state_q == EMB_ST_STROBE) && (state_d == EMB_ST_TAIL) && !curWrite;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lowAddrDataPortOut <= EMB_RST_BYTE;
			lowAddrDataPortOe <= 1'b0;
			highAddrPortOut <= EMB_RST_BYTE;
			highAddrPortOe <= 1'b0;
			latchStrobe <= 1'b0;
		end
		else
		begin
			lowAddrDataPortOut <= lowOutN;
			lowAddrDataPortOe <= lowOeN;
			highAddrPortOut <= addrN[15:8];
			highAddrPortOe <= busyN;
			latchStrobe <= aleN;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			programStoreStrobe_n <= 1'b1;
			dataReadStrobe_n <= 1'b1;
			dataWriteStrobe_n <= 1'b1;
		end
		else
		begin
			programStoreStrobe_n <= !(strobeN && codeN);
			dataReadStrobe_n <= !(strobeN && kindN == EMB_KIND_DATA_READ);
			dataWriteStrobe_n <= !(strobeN && writeN);
		end
	end

	// ----------------------------------------------------------------
	// Core-side answer
	// ----------------------------------------------------------------
	logic reqDone_q;
	logic reqInternal_q;
	logic [7:0] rdData_q;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reqReady_q <= 1'b0;
			reqDone_q <= 1'b0;
			reqInternal_q <= 1'b0;
			rdData_q <= EMB_RST_BYTE;
		end
		else
		begin
			reqReady_q <= (state_d == EMB_ST_IDLE) && !coreReset_q && !goExternal;
			reqDone_q <= goInternal || ((state_q == EMB_ST_TAIL) && !coreReset_q);
			if (accept)
				reqInternal_q <= internalHit;
			if (capture)
				rdData_q <= busSync3_q;
		end
	end

	assign reqReady = reqReady_q;
	assign reqDone = reqDone_q;
	assign reqInternal = reqInternal_q;
	assign reqRdData = rdData_q;
	assign coreReset = coreReset_q;

endmodule : emb_bus_port

`default_nettype wire

// [emb_bus_port_checker.sv]
// Pin-level assertions for the bus port
`timescale 1ns/1ps
`default_nettype none
module emb_bus_port_checker (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic resetPin,
	input wire logic latchStrobeOff,
	input wire logic reqDone,
	input wire logic reqInternal,
	input wire logic coreReset,
	input wire logic lowAddrDataPortOe,
	input wire logic highAddrPortOe,
	input wire logic latchStrobe,
	input wire logic programStoreStrobe_n,
	input wire logic dataReadStrobe_n,
	input wire logic dataWriteStrobe_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	logic [5:0] pinCnt_q;
	logic anyFell;
	// Run length of the reset pin; saturates so it never wraps
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			pinCnt_q <= 6'h00;
		else if (!resetPin)
			pinCnt_q <= 6'h00;
		else if (pinCnt_q != 6'h3f)
			pinCnt_q <= pinCnt_q + 6'h01;
	assign anyFell = !(programStoreStrobe_n & dataReadStrobe_n & dataWriteStrobe_n);
	a_pin_reset: assert property (pinCnt_q == 6'h20 |-> coreReset)
		else $error("reset pin held but core runs");
	a_reset_idle: assert property (coreReset && $past(coreReset) |-> !anyFell && !latchStrobe
		&& !lowAddrDataPortOe && !highAddrPortOe)
		else $error("bus not idle in reset");
	a_int_quiet: assert property (reqDone && reqInternal |-> programStoreStrobe_n
		&& !lowAddrDataPortOe && !highAddrPortOe)
		else $error("internal hit touched the bus");
	a_one_strobe: assert property ($onehot0({!programStoreStrobe_n, !dataReadStrobe_n,
		!dataWriteStrobe_n}))
		else $error("two access strobes at once");
	a_latch_first: assert property ($rose(anyFell) |-> !latchStrobe && $past(latchStrobe, 2)
		&& highAddrPortOe)
		else $error("strobe without latched address");
	a_code_width: assert property ($fell(programStoreStrobe_n) |->
		(!programStoreStrobe_n && !lowAddrDataPortOe)[*3] ##[1:4] programStoreStrobe_n)
		else $error("program strobe width wrong");
	a_write_drive: assert property ($fell(dataWriteStrobe_n) |->
		(!dataWriteStrobe_n && lowAddrDataPortOe)[*6] ##1 dataWriteStrobe_n)
		else $error("write strobe width or data wrong");
	a_read_bus: assert property (!dataReadStrobe_n |-> !lowAddrDataPortOe && highAddrPortOe)
		else $error("read strobe with port driven");
	a_quiet_latch: assert property ($rose(latchStrobe) && latchStrobeOff |->
		lowAddrDataPortOe && highAddrPortOe)
		else $error("suppressed latch strobe toggled");
	c_fetch: cover property ($fell(programStoreStrobe_n));
	c_write: cover property ($fell(dataWriteStrobe_n));
	c_int: cover property (reqDone && reqInternal);
endmodule : emb_bus_port_checker
`default_nettype wire

// [emb_mem_model.sv]
// External code store, data store and address latch
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
	input wire logic clk_sys,
	input wire logic slow,
	input wire logic [7:0] lowOut,
	input wire logic lowOe,
	input wire logic [7:0] highOut,
	input wire logic ale,
	input wire logic codeStb_n,
	input wire logic rd_n,
	input wire logic wr_n,
	output logic [7:0] lowIn,
	output logic [15:0] addrSeen
);
	logic [7:0] ram [0:255];
	logic [7:0] lat;
	logic [7:0] code;
	int held = 0;
	always @(posedge clk_sys)
		if (ale)
			lat <= lowOut;
	always @(posedge clk_sys)
		held <= (codeStb_n & rd_n) ? 0 : held + 1;
	always @(negedge (codeStb_n & rd_n & wr_n))
		addrSeen = {highOut, lat};
	always @(posedge wr_n)
		if (lowOe)
			ram[lat] = lowOut;
	assign code = lat ^ highOut ^ 8'h5a;
	// Released port floats to the pull-ups; slow mode delays data one clock
	assign lowIn = lowOe ? lowOut : (!codeStb_n && held >= slow) ? code
		: (!rd_n && held >= slow) ? ram[lat] : 8'hff;
endmodule : emb_mem_model
`default_nettype wire

// [emb_bus_port_tb_top.sv]
// Testbench for the external memory bus port
`timescale 1ns/1ps
`default_nettype none
module emb_bus_port_tb_top;
	import emb_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic resetPin = 1'b0;
	logic externalAccessSelectPin = 1'b1;
	logic latchStrobeOff = 1'b0;
	logic reqValid = 1'b0;
	emb_kind_e reqKind = EMB_KIND_FETCH;
	logic [15:0] reqAddr = 16'h0000;
	logic [7:0] reqWrData = 8'h00;
	logic slow = 1'b0;
	logic reqReady, reqDone, reqInternal, coreReset, lowAddrDataPortOe, highAddrPortOe;
	logic latchStrobe, programStoreStrobe_n, dataReadStrobe_n, dataWriteStrobe_n;
	logic [7:0] reqRdData, lowAddrDataPortIn, lowAddrDataPortOut, highAddrPortOut;
	logic [15:0] addrSeen;
	int err_count = 0;
	int cmp_count = 0;
	int aleRise = 0;
	int codeStbFall = 0;
	always #5 clk_sys = ~clk_sys;
	always @(posedge latchStrobe) aleRise++;
	always @(negedge programStoreStrobe_n) codeStbFall++;
	emb_bus_port i_emb_bus_port (.*);
	emb_mem_model i_emb_mem_model (.clk_sys(clk_sys), .slow(slow), .lowOut(lowAddrDataPortOut),
		.lowOe(lowAddrDataPortOe), .highOut(highAddrPortOut), .ale(latchStrobe),
		.codeStb_n(programStoreStrobe_n), .rd_n(dataReadStrobe_n), .wr_n(dataWriteStrobe_n),
		.lowIn(lowAddrDataPortIn), .addrSeen(addrSeen));
	// ----
	// Shared tasks
	// ----
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wt
	task automatic req(input emb_kind_e k, input logic [15:0] a, input logic [7:0] d);
		int n;
		n = 0;
		wt(1);
		reqKind = k;
		reqAddr = a;
		reqWrData = d;
		reqValid = 1'b1;
		do @(negedge clk_sys); while (reqReady !== 1'b1 && ++n < 99);
		wt(1);
		reqValid = 1'b0;
		do @(negedge clk_sys); while (reqDone !== 1'b1 && ++n < 199);
		// A request that never finishes counts as a mismatch
		if (reqDone !== 1'b1)
			err_count++;
		// Hand back control just after a rising edge, as all stimulus is
		wt(1);
	endtask : req
	task automatic ext(input emb_kind_e k, input logic [15:0] a);
		int p;
		p = codeStbFall;
		req(k, a, 8'h00);
		check("internal", reqInternal, 1'b0);
		check("code", reqRdData, a[7:0] ^ a[15:8] ^ 8'h5a);
		check("addr", addrSeen, a);
		check("strobes", codeStbFall, p + 1);
	endtask : ext
	task automatic finish_test();
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	// ----
	// Scenarios
	// ----
	task automatic t_internal();
		int p;
		p = codeStbFall;
		req(EMB_KIND_FETCH, 16'h0123, 8'h00);
		check("internal", reqInternal, 1'b1);
		req(EMB_KIND_CODE_READ, 16'h0fff, 8'h00);
		check("internal", reqInternal, 1'b1);
		check("strobes", codeStbFall, p);
	endtask : t_internal
	task automatic t_data();
		req(EMB_KIND_DATA_WRITE, 16'habcd, 8'h5a);
		req(EMB_KIND_DATA_WRITE, 16'h1234, 8'h33);
		slow = 1'b1;
		req(EMB_KIND_DATA_READ, 16'habcd, 8'h00);
		slow = 1'b0;
		check("data", reqRdData, 8'h5a);
		check("addr", addrSeen, 16'habcd);
		ext(EMB_KIND_FETCH, 16'h1234);
	endtask : t_data
	task automatic t_latch_off();
		int a;
		latchStrobeOff = 1'b1;
		wt(10);
		a = aleRise;
		wt(30);
		check("quiet", aleRise, a);
		ext(EMB_KIND_CODE_READ, 16'h2000);
		wt(30);
		check("pulses", aleRise, a + 1);
		latchStrobeOff = 1'b0;
		wt(30);
		check("free", aleRise > a + 4, 1'b1);
	endtask : t_latch_off
	task automatic t_pin_reset();
		resetPin = 1'b1;
		wt(10);
		resetPin = 1'b0;
		wt(8);
		check("short", coreReset, 1'b0);
		// Held past the checker's run-length mark so its reset check is reached
		resetPin = 1'b1;
		wt(34);
		check("held", coreReset, 1'b1);
		resetPin = 1'b0;
		req(EMB_KIND_FETCH, 16'h0042, 8'h00);
		check("back", reqInternal, 1'b1);
	endtask : t_pin_reset
	initial
	begin
		#16;
		check("idle", {programStoreStrobe_n, dataReadStrobe_n, dataWriteStrobe_n}, 3'h7);
		rst_n = 1'b1;
		wt(20);
		check("silent", aleRise, 0);
		t_internal();
		ext(EMB_KIND_FETCH, 16'h1000);
		ext(EMB_KIND_CODE_READ, 16'hfedc);
		externalAccessSelectPin = 1'b0;
		wt(5);
		ext(EMB_KIND_FETCH, 16'h0010);
		externalAccessSelectPin = 1'b1;
		wt(5);
		t_data();
		t_latch_off();
		t_pin_reset();
		finish_test();
	end
	initial
	begin
		#100000;
		err_count++;
		finish_test();
	end
endmodule : emb_bus_port_tb_top
bind emb_bus_port emb_bus_port_checker i_emb_bus_port_checker (.*);
`default_nettype wire
